// [nbh_defs.vh]
// constants for the nand bus host controller
`ifndef NBH_DEFS_VH
`define NBH_DEFS_VH
// host request kinds
`define NBH_OP_CMD      2'h0
`define NBH_OP_ADDR     2'h1
`define NBH_OP_WDATA    2'h2
`define NBH_OP_RDATA    2'h3
// strobe timing in ns and derived cycles at 4 ns period
`define NBH_CLK_NS      4
`define NBH_T_SETUP_NS  12
`define NBH_T_LOW_NS    12
`define NBH_T_HIGH_NS   12
`define NBH_T_REA_NS    20
`define NBH_SETUP_CYC   ((`NBH_T_SETUP_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`define NBH_LOW_CYC     ((`NBH_T_LOW_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`define NBH_HIGH_CYC    ((`NBH_T_HIGH_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`define NBH_REA_CYC     ((`NBH_T_REA_NS + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
// status bit holding ready in the per-unit status byte
`define NBH_SR_READY    6
`endif

// [nbh_sync2.v]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module nbh_sync2 #(
  parameter W = 1
) (
  input  wire         clock,  // system clock
  input  wire         rst_n,  // sync reset, active low
  input  wire [W-1:0] d,      // asynchronous input
  input  wire [W-1:0] rst_val, // value loaded while reset is held
  output reg  [W-1:0] q       // synchronised output
);
  reg [W-1:0] meta_reg;  // first stage, read only by q

  // two stage chain; reset loads rst_val
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= rst_val;
      q        <= rst_val;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [nbh_host.v]
// nand bus host controller: drives cycles over the pins of one target
// Overview of operation
// - shared lines carry cmd, addr, data both ways
// - wide mode uses sixteen bus lines
// - each channel has own bus and controls
// - latch inputs mark command, address, data cycles
// - word bit 0 lsb, byte 0 low
// - reserved bits zero, host ignores them
`timescale 1ns/1ns
`default_nettype none
`include "nbh_defs.vh"
// one instance serves one channel with its own lines and controls
// several channels are built by instantiating this block once per channel
module nbh_host (
  input  wire        clock,           // 250 mhz system clock
  input  wire        rst_n,           // sync reset, active low
  input  wire        req_valid,       // request present
  output wire        req_ready,       // request taken this cycle
  input  wire [1:0]  req_op,          // cycle kind
  input  wire [15:0] req_wdata,       // command, address or write data
  input  wire        req_last,        // release select after this cycle
  input  wire        req_wait_ready,  // wait for ready before the cycle
  input  wire        wide_mode,       // sixteen line bus
  output reg         rsp_valid,       // read word valid, one cycle
  output reg  [15:0] rsp_rdata,       // read word, unused lanes zero
  output reg         status_ready,    // synchronised ready/busy level
  output reg         target_select_n, // chip enable pin
  output reg         cmd_latch,       // command latch pin
  output reg         addr_latch,      // address latch pin
  output reg         write_strobe_n,  // write enable pin
  output reg         read_strobe_n,   // read enable pin
  output reg  [15:0] wide_bus_lines_o, // bus output value
  output reg         wide_bus_lines_oe, // high while host drives bus
  input  wire [15:0] wide_bus_lines_i, // bus input value
  input  wire        ready_busy_n_i   // open-drain ready/busy pin
);
  // one bus cycle walks idle, wait, setup, low, high and back to idle;
  // wait holds off a cycle until ready/busy shows ready, if asked;
  // setup puts select, latches and bus out ahead of the strobe;
  // low holds the strobe low, high holds the bus past the rising edge;
  // a read leaves the bus undriven so the target can answer;
  // every phase lasts at least one cycle even if its count is zero
  // states
  localparam S_IDLE  = 3'h0;
  localparam S_WAIT  = 3'h1;
  localparam S_SETUP = 3'h2;
  localparam S_LOW   = 3'h3;
  localparam S_HIGH  = 3'h4;

  // timing counts in cycles, cut to the counter width on purpose
  localparam integer SETUP_I = `NBH_SETUP_CYC;  // setup cycles, full width
  localparam integer LOW_I   = `NBH_LOW_CYC;    // strobe low cycles, full width
  localparam integer HIGH_I  = `NBH_HIGH_CYC;   // strobe high cycles, full width
  localparam integer REA_I   = `NBH_REA_CYC;    // read access cycles, full width
  localparam [3:0]   SETUP_N = SETUP_I[3:0];    // setup cycles
  localparam [3:0]   LOW_N   = LOW_I[3:0];      // strobe low cycles
  localparam [3:0]   HIGH_N  = HIGH_I[3:0];     // strobe high cycles
  localparam [3:0]   REA_N   = REA_I[3:0];      // read access cycles

  reg  [2:0]  state_reg;     // current state
  reg  [3:0]  cnt_reg;       // phase counter
  reg  [1:0]  op_reg;        // latched kind
  reg  [15:0] wdata_reg;     // latched write word
  reg         last_reg;      // latched release flag
  reg         wait_reg;      // latched wait flag
  wire [15:0] bus_sync;      // synchronised bus
  wire        rb_sync;       // synchronised ready/busy

  // pins pass two flops before use; the read word therefore shows
  // the lines two cycles before the read strobe rises, three cycles
  // after it falls, as the access count is not lengthened for them
  nbh_sync2 #(.W(17)) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .d       ({ready_busy_n_i, wide_bus_lines_i}),
    .rst_val (17'h00000),
    .q       ({rb_sync, bus_sync})
  );

  // mask upper lane in byte mode; low byte is byte 0
  // shared by the write word and the read word
  function [15:0] lane_mask;
    input [15:0] v;
    input        wide;
    begin
      lane_mask = wide ? v : {8'h00, v[7:0]};
    end
  endfunction

  // phase length helper
  // a zero count would otherwise wrap to sixteen cycles
  function [3:0] at_least1;
    input [3:0] n;
    begin
      at_least1 = (n == 4'h0) ? 4'h1 : n;
    end
  endfunction

  // combinational ready: a request waits, never drops, while busy
  assign req_ready = (state_reg == S_IDLE);  // taken on valid and ready

  // main sequencer
  always @(posedge clock) begin
    if (!rst_n) begin
      // pins idle: target released, strobes high, bus not driven
      state_reg         <= S_IDLE;
      cnt_reg           <= 4'h0;
      op_reg            <= 2'h0;
      wdata_reg         <= 16'h0000;
      last_reg          <= 1'b0;
      wait_reg          <= 1'b0;
      rsp_valid         <= 1'b0;
      rsp_rdata         <= 16'h0000;
      status_ready      <= 1'b0;
      target_select_n   <= 1'b1;
      cmd_latch         <= 1'b0;
      addr_latch        <= 1'b0;
      write_strobe_n    <= 1'b1;
      read_strobe_n     <= 1'b1;
      wide_bus_lines_o  <= 16'h0000;
      wide_bus_lines_oe <= 1'b0;
    end else begin
      // read pulse lasts one cycle unless set below
      rsp_valid    <= 1'b0;
      // third flop gives the user a clean ready level
      status_ready <= rb_sync;  // low means busy
      case (state_reg)
        // idle: copy the request when it is offered
        S_IDLE: begin
          if (req_valid) begin
            op_reg    <= req_op;
            wdata_reg <= lane_mask(req_wdata, wide_mode);
            last_reg  <= req_last;
            wait_reg  <= req_wait_ready;
            state_reg <= S_WAIT;
          end
        end
        // wait: hold off until ready if the request asks for it
        S_WAIT: begin
          // poll ready before dependent cycles
          if (!wait_reg || rb_sync) begin
            target_select_n <= 1'b0;  // select target
            cmd_latch  <= (op_reg == `NBH_OP_CMD);
            addr_latch <= (op_reg == `NBH_OP_ADDR);
            wide_bus_lines_o  <= wdata_reg;
            wide_bus_lines_oe <= (op_reg != `NBH_OP_RDATA);
            cnt_reg   <= at_least1(SETUP_N);
            state_reg <= S_SETUP;
          end
          // otherwise stay; pins keep their previous levels
        end
        // setup: select, latches and bus stand before the strobe falls
        S_SETUP: begin
          if (cnt_reg == 4'h1) begin
            if (op_reg == `NBH_OP_RDATA) begin
              // read: strobe low at least the access time
              read_strobe_n <= 1'b0;
              cnt_reg       <= at_least1(REA_N > LOW_N ? REA_N : LOW_N);
            end else begin
              // write: open the write pulse
              write_strobe_n <= 1'b0;
              cnt_reg        <= at_least1(LOW_N);
            end
            state_reg <= S_LOW;
          end else begin
            // count the setup phase down
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        // low: strobe held low, then raised
        S_LOW: begin
          if (cnt_reg == 4'h1) begin
            // rising write edge latches in target
            write_strobe_n <= 1'b1;
            if (op_reg == `NBH_OP_RDATA) begin
              // raise the strobe and keep the lines seen two cycles before
              read_strobe_n <= 1'b1;
              rsp_rdata     <= lane_mask(bus_sync, wide_mode);
              rsp_valid     <= 1'b1;
            end
            cnt_reg   <= at_least1(HIGH_N);
            state_reg <= S_HIGH;
          end else begin
            // count the low phase down
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        // high: bus held past the rising edge, then latches dropped
        S_HIGH: begin
          if (cnt_reg == 4'h1) begin
            cmd_latch         <= 1'b0;
            addr_latch        <= 1'b0;
            wide_bus_lines_oe <= 1'b0;
            if (last_reg) begin
              target_select_n <= 1'b1;  // release for standby
            end
            // select stays low between cycles of one sequence
            state_reg <= S_IDLE;
          end else begin
            // count the high phase down
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        // unused state codes fall back to idle
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [nbh_chk_asserts.sv]
// pin timing assertions for the nand bus host
`timescale 1ns/1ns
`default_nettype none
module nbh_chk (
  input wire logic        clock,             // clock
  input wire logic        rst_n,             // reset
  input wire logic        wide_mode,         // bus width
  input wire logic        rsp_valid,         // read valid
  input wire logic [15:0] rsp_rdata,         // read word
  input wire logic        target_select_n,   // select
  input wire logic        cmd_latch,         // cmd latch
  input wire logic        addr_latch,        // addr latch
  input wire logic        write_strobe_n,    // write strobe
  input wire logic        read_strobe_n,     // read strobe
  input wire logic        wide_bus_lines_oe  // host drives
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  one_kind_a: assert property (!(cmd_latch && addr_latch))
    else $error("latch clash");
  one_strobe_a: assert property (write_strobe_n || read_strobe_n)
    else $error("strobe clash");
  drive_sel_a: assert property (wide_bus_lines_oe |-> !target_select_n)
    else $error("drive unselected");
  kind_hold_a: assert property (!write_strobe_n |-> $stable({cmd_latch, addr_latch}))
    else $error("kind moved");
  wr_pulse_a: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*3] ##1 write_strobe_n)
    else $error("write pulse");
  wr_drive_a: assert property ($rose(write_strobe_n) |-> wide_bus_lines_oe && !target_select_n)
    else $error("latch undriven");
  rd_pulse_a: assert property ($fell(read_strobe_n) |-> (!read_strobe_n)[*5] ##1 (read_strobe_n && rsp_valid))
    else $error("read pulse");
  rd_float_a: assert property (!read_strobe_n |-> !wide_bus_lines_oe && !target_select_n)
    else $error("read contention");
  byte_hi_a: assert property (rsp_valid && !wide_mode |-> rsp_rdata[15:8] == 8'h00)
    else $error("upper byte");
endmodule
bind nbh_host nbh_chk chk (
  .clock             (clock),
  .rst_n             (rst_n),
  .wide_mode         (wide_mode),
  .rsp_valid         (rsp_valid),
  .rsp_rdata         (rsp_rdata),
  .target_select_n   (target_select_n),
  .cmd_latch         (cmd_latch),
  .addr_latch        (addr_latch),
  .write_strobe_n    (write_strobe_n),
  .read_strobe_n     (read_strobe_n),
  .wide_bus_lines_oe (wide_bus_lines_oe)
);
`default_nettype wire

// [nbh_dev.sv]
// behavioural nand target model
`timescale 1ns/1ns
`default_nettype none
module nbh_dev #(
  parameter BUSY_CYC = 40,    // busy length
  parameter START    = 8'h10, // start command, arbitrary
  parameter STAT     = 8'h70  // status command, arbitrary
) (
  input  wire logic        clock,    // time base
  input  wire logic        sel_n,    // target select
  input  wire logic        lat_cmd,  // cmd latch
  input  wire logic        lat_addr, // addr latch
  input  wire logic        wr_n,     // write strobe
  input  wire logic        rd_n,     // read strobe
  input  wire logic [15:0] io,       // bus level
  output logic      [15:0] dq,       // read value
  output logic             dq_oe,    // target drives
  output logic             rb        // ready, pulled up
);
  logic [7:0]  cmd_reg = 0;  // last command
  logic [15:0] dat_reg = 0;  // last data
  logic        go_reg = 0;   // start toggle
  logic        seen_reg = 0; // toggle echo
  int          busy = 0;     // busy cycles left
  // capture on strobe rise only while selected
  always @(posedge wr_n) if (!sel_n) begin
    if (lat_cmd) begin
      cmd_reg <= io[7:0];
      if (io[7:0] == START) go_reg <= ~go_reg;
    end else if (!lat_addr) dat_reg <= io;
  end
  // busy count after a start command
  always @(posedge clock) begin
    seen_reg <= go_reg;
    if (seen_reg != go_reg) busy <= BUSY_CYC;
    else if (busy > 0) busy <= busy - 1;
  end
  assign rb = (busy == 0);
  assign dq_oe = !sel_n && !rd_n;
  // ready in bit 6, reserved bits zero
  assign dq = (cmd_reg == STAT) ? {9'h000, rb, 6'h00} : dat_reg;
endmodule
`default_nettype wire

// [nbh_tb.sv]
// testbench for the nand bus host
`timescale 1ns/1ns
`default_nettype none
`include "nbh_defs.vh"
module tb_top;
  logic clock = 0, rst_n = 0, req_valid = 0, req_last = 0, req_wait_ready = 0, wide_mode = 0;
  logic [1:0] req_op = 0;
  logic [15:0] req_wdata = 0, got, io, o, dq, rsp_rdata, last_reg = 0;
  logic req_ready, rsp_valid, status_ready, sel_n, lat_cmd, lat_addr, wr_n, rd_n, oe, dq_oe, rb;
  int errors = 0, n_tests = 0, cyc = 0;
  initial forever #2 clock = ~clock;
  // released bus toggles instead of holding
  assign io = oe ? o : dq_oe ? dq : ~last_reg;
  always @(posedge clock) last_reg <= io;
  nbh_host uut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_wdata(req_wdata), .req_last(req_last),
    .req_wait_ready(req_wait_ready), .wide_mode(wide_mode), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .status_ready(status_ready), .target_select_n(sel_n),
    .cmd_latch(lat_cmd), .addr_latch(lat_addr), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
    .wide_bus_lines_o(o), .wide_bus_lines_oe(oe), .wide_bus_lines_i(io), .ready_busy_n_i(rb));
  nbh_dev dev (.clock(clock), .sel_n(sel_n), .lat_cmd(lat_cmd), .lat_addr(lat_addr),
    .wr_n(wr_n), .rd_n(rd_n), .io(io), .dq(dq), .dq_oe(dq_oe), .rb(rb));
  task end_sim;
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // one bus cycle: offer, wait for take, then for idle
  task op(input [1:0] k, input [15:0] d, input l, w);
    got = 16'h0000;
    @(posedge clock);
    req_op <= k;
    req_wdata <= d;
    req_last <= l;
    req_wait_ready <= w;
    req_valid <= 1'b1;
    do @(negedge clock); while (req_ready !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(negedge clock);
      if (rsp_valid === 1'b1) got = rsp_rdata;
    end while (req_ready !== 1'b1);
  endtask
  // byte mode write and read back; the address would read as status if latched as command
  task t_byte;
    op(2'h0, 16'h0080, 0, 0);
    op(2'h1, 16'h0070, 0, 0);
    op(2'h2, 16'ha5c3, 1, 0);
    op(2'h3, 16'h0000, 1, 0);
    chk(got, 16'h00c3);
  endtask
  // wide mode keeps both bytes in place
  task t_wide;
    @(posedge clock);
    wide_mode <= 1'b1;
    op(2'h0, 16'h0080, 0, 0);
    op(2'h2, 16'h5a3c, 0, 0);
    op(2'h3, 16'h0000, 1, 0);
    chk(got, 16'h5a3c);
  endtask
  // start, wait on busy, then read status
  task t_busy;
    op(2'h0, 16'h0010, 1, 0);
    repeat (4) @(negedge clock);
    chk({15'h0, status_ready}, 16'h0000);
    op(2'h0, 16'h0070, 0, 1);
    chk({15'h0, status_ready}, 16'h0001);
    op(2'h3, 16'h0000, 1, 0);
    chk(got, 16'h0001 << `NBH_SR_READY);
  endtask
  // mid-run reset idles the pins, then a status read works again
  task t_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({11'h0, req_ready, status_ready, sel_n, oe, rsp_valid}, 16'h0014);
    @(posedge clock);
    rst_n <= 1'b1;
    op(2'h3, 16'h0000, 1, 0);
    chk(got, 16'h0001 << `NBH_SR_READY);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk({14'h0, sel_n, oe}, 16'h0002);
    t_byte;
    t_wide;
    t_busy;
    t_reset;
    end_sim;
  end
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      end_sim;
    end
  end
endmodule
`default_nettype wire
